/* pic_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_asserts (
  input wire logic CLK_IN, // system clock
  input wire logic RST_IN, // sync reset, high
  input wire logic [pic_pkg::PIX_W-1:0] pixel_data, // pixel bus
  input wire logic pixel_clock_pos, // link clock
  input wire logic pixel_clock_neg, // odd-edge clock
  input wire logic active_video_qualifier, // active video
  input wire logic bus_width_select, // high = 24-bit
  input wire logic dual_edge_select, // high = both edges
  input wire logic host_select_reset, // high = host mode
  input wire logic skew_strap_enable, // skew strap
  input wire logic [pic_pkg::GP_W-1:0] general_inputs, // control inputs
  input wire logic [pic_pkg::GP_W-1:0] general_inputs_oe, // driven bits
  input wire logic WORD_VALID_OUT, // word strobe
  input wire logic WIDE_MODE_OUT, // latched width
  input wire logic MGMT_ACTIVE_OUT, // management on
  input wire logic MGMT_RESET_OUT // management reset
);
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (RST_IN);

  // ----------------------------------------
  // wire rules kept by the source
  // ----------------------------------------
  property p_rsvd_low;
    !bus_width_select |-> pixel_data[15:12] == 4'h0;
  endproperty
  a_rsvd_low: assert property (p_rsvd_low) else $error("reserved lines not low");
  property p_neg_low;
    (bus_width_select || dual_edge_select) |-> !pixel_clock_neg;
  endproperty
  a_neg_low: assert property (p_neg_low) else $error("unused neg clock not low");
  // masked by the enables: an undriven bit is pulled low, not a change
  property p_gp_blank;
    !host_select_reset && !skew_strap_enable && $changed(general_inputs & general_inputs_oe)
      |-> !active_video_qualifier || !$past(active_video_qualifier);
  endproperty
  a_gp_blank: assert property (p_gp_blank) else $error("general inputs moved in active");
  property p_skew_host;
    host_select_reset |-> skew_strap_enable;
  endproperty
  a_skew_host: assert property (p_skew_host) else $error("skew strap low in host mode");

  // ----------------------------------------
  // device side
  // ----------------------------------------
  // captures are at least one half period (4 cycles) apart
  property p_valid_gap;
    WORD_VALID_OUT |=> !WORD_VALID_OUT [*3];
  endproperty
  a_valid_gap: assert property (p_valid_gap) else $error("words closer than an edge");
  property p_mgmt_excl;
    !host_select_reset [*4] |-> MGMT_RESET_OUT && !MGMT_ACTIVE_OUT;
  endproperty
  a_mgmt_excl: assert property (p_mgmt_excl) else $error("management on while reset");
  property p_wide_follow;
    $rose(bus_width_select) && !host_select_reset |-> ##[1:6] WIDE_MODE_OUT;
  endproperty
  a_wide_follow: assert property (p_wide_follow) else $error("wide mode not taken");
  property p_host_hold;
    host_select_reset [*6] |-> $stable(WIDE_MODE_OUT);
  endproperty
  a_host_hold: assert property (p_host_hold) else $error("mode moved in host mode");
  property p_mgmt_on;
    $rose(host_select_reset) |-> ##[1:6] MGMT_ACTIVE_OUT;
  endproperty
  a_mgmt_on: assert property (p_mgmt_on) else $error("management not enabled");
endmodule
`default_nettype wire

/* pic_device.sv */
// Functional notes
// - wide mode: upper lines form top half
// - narrow mode: top eight lines feed strap
// - controller holds reserved and unused lines low
// - wide mode: lower lines form bottom half
// - narrow mode: twelve bits per latching edge
// - positive pixel clock captures every mode
// - negative clock only narrow single-edge, odd
// - controller ties negative clock low otherwise
// - controller drives qualifier high active, low blank
// - qualifier marks words active or blanking
// - floating control inputs read as low
// - general inputs change only during blanking
// - strap mode plus skew enable: skew setting
// - host mode plus skew enable: address bits
// - dual edge latches both positive clock edges
// - host select low holds management reset
// - strap high wide mode, low narrow
// - skew strap high whenever management active
`timescale 1ns/1ns
`default_nettype none
module pic_device (
  pic_if.dev LINK, // pixel bus from the controller
  input wire logic CLK_IN, // system clock
  input wire logic RST_IN, // sync reset, high
  output logic [pic_pkg::PIX_W-1:0] PIXEL_OUT, // captured pixel word
  output logic WORD_VALID_OUT, // one-cycle word strobe
  output logic ACTIVE_OUT, // word is active video
  output logic HSYNC_OUT, // line sync with word
  output logic VSYNC_OUT, // frame sync with word
  output logic WIDE_MODE_OUT, // 24-bit mode latched
  output logic DUAL_MODE_OUT, // dual edge latched
  output logic [pic_pkg::STRAP_W-1:0] STRAP_OUT, // user strap bits
  output logic [pic_pkg::GP_W-1:0] GP_OUT, // general inputs
  output logic [pic_pkg::GP_W-1:0] SKEW_OUT, // skew setting
  output logic [pic_pkg::GP_W-1:0] ADDR_LOW_OUT, // low address bits
  output logic MGMT_ACTIVE_OUT, // management bus on
  output logic MGMT_RESET_OUT // management held in reset
);
  import pic_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pic_pins_t meta;
    pic_pins_t pins;
    logic pos_prev;
    logic neg_prev;
    logic wide;
    logic dual;
    logic phase;
    logic prev_qual;
    logic [HALF_W-1:0] low_half;
    logic [PIX_W-1:0] pixel;
    logic valid;
    logic active;
    logic hsync;
    logic vsync;
    logic [STRAP_W-1:0] strap;
    logic [GP_W-1:0] gp;
    logic [GP_W-1:0] skew;
    logic [GP_W-1:0] addr;
    logic mgmt_active;
    logic mgmt_reset;
  } pic_dev_t;

  pic_dev_t q;
  pic_dev_t d;
  pic_pins_t raw;
  logic [GP_W-1:0] gp_pin;
  logic pos_rise;
  logic pos_fall;
  logic neg_rise;
  logic capture;
  logic pair_ok;
  pic_gp_t route;

  // ----------------------------------------
  // pin conditioning
  // ----------------------------------------

  // weak pull-down on each multi-function input
  for (genvar i = 0; i < GP_W; i++)
  begin : g_pull
    assign gp_pin[i] = LINK.general_inputs_oe[i] ? LINK.general_inputs[i] : 1'b0;
  end

  // all pins go through one bundle so every bit sees the same two-flop delay
  assign raw = {
    LINK.pixel_clock_pos,
    LINK.pixel_clock_neg,
    LINK.active_video_qualifier,
    LINK.hsync,
    LINK.vsync,
    LINK.bus_width_select,
    LINK.dual_edge_select,
    LINK.host_select_reset,
    LINK.skew_strap_enable,
    gp_pin,
    LINK.pixel_data
  };

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------

  // which job the three control inputs do
  function automatic pic_gp_t gp_route(input logic host_sel, input logic skew_en);
    case ({host_sel, skew_en})
      2'b00: gp_route = PIC_GP_GENERAL;
      2'b01: gp_route = PIC_GP_SKEW;
      2'b11: gp_route = PIC_GP_ADDR;
      default: gp_route = PIC_GP_HOLD;
    endcase
  endfunction

  assign route = gp_route(q.pins.host_sel, q.pins.skew_en);

  // edges of the synchronised clocks; only the second stage is looked at
  assign pos_rise = q.pins.clk_pos & ~q.pos_prev;
  assign pos_fall = ~q.pins.clk_pos & q.pos_prev;
  assign neg_rise = q.pins.clk_neg & ~q.neg_prev;

  // latching edges per mode; the negative clock is ignored unless narrow single edge
  always_comb
  begin
    capture = 1'b0;
    if (q.dual)
      capture = pos_rise | pos_fall;
    else if (q.wide)
      capture = pos_rise;
    else
      capture = pos_rise | neg_rise;
  end

  // a half is only paired with the one before it if both share a qualifier
  assign pair_ok = q.phase && (q.pins.qual == q.prev_qual);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb
  begin
    d = q;
    d.meta = raw;
    d.pins = q.meta;
    d.pos_prev = q.pins.clk_pos;
    d.neg_prev = q.pins.clk_neg;
    d.valid = 1'b0;
    // mode pins double as bus lines in host mode, so hold the last strapped mode
    if (!q.pins.host_sel)
    begin
      d.wide = q.pins.bus_width;
      d.dual = q.pins.dual_edge;
    end
    // management side follows the host select level
    d.mgmt_active = q.pins.host_sel;
    d.mgmt_reset = ~q.pins.host_sel;
    // narrow mode: top eight lines carry user straps, not pixels
    if (!q.wide)
      d.strap = q.pins.data[STRAP_LSB +: STRAP_W];
    // route the control inputs
    case (route)
      PIC_GP_GENERAL: d.gp = q.pins.gp;
      PIC_GP_SKEW: d.skew = q.pins.gp;
      PIC_GP_ADDR: d.addr = q.pins.gp;
      default: d.gp = q.gp;
    endcase
    // capture
    if (capture)
    begin
      if (q.wide)
      begin
        d.pixel[PIX_W-1:HALF_W] = q.pins.data[PIX_W-1:HALF_W];
        d.pixel[HALF_W-1:0] = q.pins.data[HALF_W-1:0];
        d.valid = 1'b1;
        d.active = q.pins.qual;
        d.hsync = q.pins.hsync;
        d.vsync = q.pins.vsync;
      end
      else if (pair_ok)
      begin
        // second half completes the word; first half was the low part
        d.pixel = {q.pins.data[HALF_W-1:0], q.low_half};
        d.valid = 1'b1;
        d.active = q.pins.qual;
        d.hsync = q.pins.hsync;
        d.vsync = q.pins.vsync;
        d.phase = 1'b0;
      end
      else
      begin
        d.low_half = q.pins.data[HALF_W-1:0];
        d.phase = 1'b1;
      end
      d.prev_qual = q.pins.qual;
    end
    // leaving narrow mode drops any half word in flight
    if (q.wide)
      d.phase = 1'b0;
  end

  // state register
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
      q <= '0;
    else
      q <= d;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign PIXEL_OUT = q.pixel;
  assign WORD_VALID_OUT = q.valid;
  assign ACTIVE_OUT = q.active;
  assign HSYNC_OUT = q.hsync;
  assign VSYNC_OUT = q.vsync;
  assign WIDE_MODE_OUT = q.wide;
  assign DUAL_MODE_OUT = q.dual;
  assign STRAP_OUT = q.strap;
  assign GP_OUT = q.gp;
  assign SKEW_OUT = q.skew;
  assign ADDR_LOW_OUT = q.addr;
  assign MGMT_ACTIVE_OUT = q.mgmt_active;
  assign MGMT_RESET_OUT = q.mgmt_reset;

endmodule
`default_nettype wire

/* pic_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface pic_if;

  // ----------------------------------------
  // parallel pixel bus, clocks and straps
  // ----------------------------------------
  logic [pic_pkg::PIX_W-1:0] pixel_data;
  logic pixel_clock_pos;
  logic pixel_clock_neg;
  logic active_video_qualifier;
  logic hsync;
  logic vsync;
  logic bus_width_select;
  logic dual_edge_select;
  logic host_select_reset;
  logic skew_strap_enable;
  // undriven bits float and the device pulls them low
  logic [pic_pkg::GP_W-1:0] general_inputs;
  logic [pic_pkg::GP_W-1:0] general_inputs_oe;

  modport dev (
    input pixel_data, pixel_clock_pos, pixel_clock_neg, active_video_qualifier,
    input hsync, vsync, bus_width_select, dual_edge_select, host_select_reset,
    input skew_strap_enable, general_inputs, general_inputs_oe
  );

  modport src (
    output pixel_data, pixel_clock_pos, pixel_clock_neg, active_video_qualifier,
    output hsync, vsync, bus_width_select, dual_edge_select, host_select_reset,
    output skew_strap_enable, general_inputs, general_inputs_oe
  );

endinterface
`default_nettype wire

/* pic_pkg.sv */
`default_nettype none
package pic_pkg;

  // ----------------------------------------
  // bus widths and field positions
  // ----------------------------------------
  localparam int PIX_W = 24;
  localparam int HALF_W = 12;
  localparam int STRAP_W = 8;
  localparam int STRAP_LSB = 16;
  localparam int RSVD_W = 4;
  localparam int GP_W = 3;

  // ----------------------------------------
  // link clock timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int LINK_PERIOD_NS = 400;
  localparam int HALF_CYCLES = (LINK_PERIOD_NS / 2) * (CLK_HZ / 1_000_000) / 1000;
  localparam logic [2:0] HALF_LAST = 3'(HALF_CYCLES - 1);
  // data changes mid-way through a half period, well away from both edges
  localparam logic [2:0] EMIT_AT = 3'(HALF_CYCLES / 4);
  localparam logic [15:0] HSYNC_ITEMS = 16'h0002;

  // ----------------------------------------
  // controller register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_GP = 5'h04;
  localparam logic [ADDR_W-1:0] REG_STRAP = 5'h08;
  localparam logic [ADDR_W-1:0] REG_LEN = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h10;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_WIDE = 1;
  localparam int CTRL_DUAL = 2;
  localparam int CTRL_HOST = 3;
  localparam int CTRL_SKEW = 4;
  localparam int CTRL_VSYNC = 5;
  localparam int CTRL_GPDRV = 6;
  localparam int CTRL_W = 7;
  localparam int LEN_BLK_LSB = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h02;
  localparam logic [15:0] ACT_LEN_RST = 16'h0010;
  localparam logic [15:0] BLK_LEN_RST = 16'h0008;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    PIC_IDLE = 2'b00,
    PIC_ACTIVE = 2'b01,
    PIC_BLANK = 2'b11
  } pic_line_t;

  typedef enum logic [1:0] {
    PIC_GP_GENERAL = 2'b00,
    PIC_GP_SKEW = 2'b01,
    PIC_GP_ADDR = 2'b11,
    PIC_GP_HOLD = 2'b10
  } pic_gp_t;

  typedef struct packed {
    logic clk_pos;
    logic clk_neg;
    logic qual;
    logic hsync;
    logic vsync;
    logic bus_width;
    logic dual_edge;
    logic host_sel;
    logic skew_en;
    logic [GP_W-1:0] gp;
    logic [PIX_W-1:0] data;
  } pic_pins_t;

endpackage
`default_nettype wire

/* pic_source.sv */
`timescale 1ns/1ns
`default_nettype none
module pic_source (
  pic_if.src LINK, // pixel bus towards the device
  input wire logic CLK_IN, // system clock
  input wire logic RST_IN, // sync reset, high
  input wire logic [pic_pkg::ADDR_W-1:0] AVS_ADDRESS_IN, // byte address
  input wire logic AVS_READ_IN, // read request
  input wire logic AVS_WRITE_IN, // write request
  input wire logic [31:0] AVS_WRITEDATA_IN, // write data
  output logic [31:0] AVS_READDATA_OUT, // read data
  output logic AVS_WAITREQUEST_OUT // stall, high
);
  import pic_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [GP_W-1:0] gp_stage;
    logic [GP_W-1:0] gp_live;
    logic [GP_W-1:0] gp_oe;
    logic [STRAP_W-1:0] strap;
    logic [15:0] act_len;
    logic [15:0] blk_len;
    pic_line_t line;
    logic [15:0] item_cnt;
    logic [15:0] line_cnt;
    logic half;
    logic [PIX_W-1:0] pix;
    logic [2:0] div;
    logic clk_pos;
    logic clk_neg;
    logic [PIX_W-1:0] data;
    logic qual;
    logic hsync;
    logic vsync;
    logic sken;
    logic wait_req;
    logic [31:0] rdata;
  } pic_src_t;

  pic_src_t q;
  pic_src_t d;
  logic wide;
  logic dual;
  logic emit;
  logic seg_done;
  logic [PIX_W-1:0] word;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  assign wide = q.ctrl[CTRL_WIDE];
  assign dual = q.ctrl[CTRL_DUAL];
  // 24-bit single edge only takes the rising edge, so skip the high half
  assign emit = (q.div == EMIT_AT) && (!wide || dual || !q.clk_pos);
  assign word = (q.line == PIC_ACTIVE) ? q.pix : '0;
  // a zero length counts as one so a segment can never stick
  assign seg_done = ({1'b0, q.item_cnt} + 17'h0_0001) >=
    {1'b0, (q.line == PIC_ACTIVE) ? q.act_len : q.blk_len};

  // next state
  always_comb
  begin
    d = q;
    // slave answers one cycle after the request is seen
    d.wait_req = 1'b1;
    if ((AVS_READ_IN || AVS_WRITE_IN) && q.wait_req)
    begin
      d.wait_req = 1'b0;
      case (AVS_ADDRESS_IN)
        REG_CTRL: d.rdata = {25'h000_0000, q.ctrl};
        REG_GP: d.rdata = {29'h0000_0000, q.gp_stage};
        REG_STRAP: d.rdata = {24'h00_0000, q.strap};
        REG_LEN: d.rdata = {q.blk_len, q.act_len};
        REG_STATUS: d.rdata = {q.line_cnt, 13'h0000, q.line, q.qual};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    if (AVS_WRITE_IN && !q.wait_req)
    begin
      case (AVS_ADDRESS_IN)
        REG_CTRL: d.ctrl = AVS_WRITEDATA_IN[CTRL_W-1:0];
        REG_GP: d.gp_stage = AVS_WRITEDATA_IN[GP_W-1:0];
        REG_STRAP: d.strap = AVS_WRITEDATA_IN[STRAP_W-1:0];
        REG_LEN:
        begin
          d.act_len = AVS_WRITEDATA_IN[15:0];
          d.blk_len = AVS_WRITEDATA_IN[LEN_BLK_LSB +: 16];
        end
        default: d.rdata = q.rdata;
      endcase
    end
    // management bus needs the skew strap high
    // taken from the next ctrl so the strap never lags the host select pin
    d.sken = d.ctrl[CTRL_HOST] | d.ctrl[CTRL_SKEW];
    // link clock divider
    if (q.div == HALF_LAST)
    begin
      d.div = 3'h0;
      d.clk_pos = ~q.clk_pos;
    end
    else
    begin
      d.div = q.div + 3'h1;
    end
    // next ctrl, so the neg clock drops in the same cycle as the mode pins move
    d.clk_neg = (!d.ctrl[CTRL_WIDE] && !d.ctrl[CTRL_DUAL]) ? ~d.clk_pos : 1'b0;
    // one item per capturing edge
    if (emit)
    begin
      d.qual = (q.line == PIC_ACTIVE);
      d.hsync = (q.line == PIC_BLANK) && (q.item_cnt < HSYNC_ITEMS);
      d.vsync = q.ctrl[CTRL_VSYNC];
      if (wide)
        d.data = word;
      else
        d.data = {q.strap, {RSVD_W{1'b0}}, q.half ? word[PIX_W-1:HALF_W] : word[HALF_W-1:0]};
      // dropping the driver also moves the pin level, so only in blanking
      if (q.line != PIC_ACTIVE)
      begin
        d.gp_live = q.gp_stage;
        d.gp_oe = {GP_W{q.ctrl[CTRL_GPDRV]}};
      end
      if (!wide && !q.half)
      begin
        d.half = 1'b1;
      end
      else
      begin
        d.half = 1'b0;
        case (q.line)
          PIC_IDLE:
          begin
            d.item_cnt = 16'h0000;
            if (q.ctrl[CTRL_RUN])
              d.line = PIC_ACTIVE;
          end
          PIC_ACTIVE:
          begin
            d.pix = q.pix + 24'h00_0001;
            d.item_cnt = seg_done ? 16'h0000 : q.item_cnt + 16'h0001;
            if (seg_done)
              d.line = PIC_BLANK;
          end
          PIC_BLANK:
          begin
            d.item_cnt = seg_done ? 16'h0000 : q.item_cnt + 16'h0001;
            if (seg_done)
            begin
              d.line = q.ctrl[CTRL_RUN] ? PIC_ACTIVE : PIC_IDLE;
              d.line_cnt = q.line_cnt + 16'h0001;
            end
          end
          default: d.line = PIC_IDLE;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.act_len <= ACT_LEN_RST;
      q.blk_len <= BLK_LEN_RST;
      q.wait_req <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign AVS_READDATA_OUT = q.rdata;
  assign AVS_WAITREQUEST_OUT = q.wait_req;
  assign LINK.pixel_data = q.data;
  assign LINK.pixel_clock_pos = q.clk_pos;
  assign LINK.pixel_clock_neg = q.clk_neg;
  assign LINK.active_video_qualifier = q.qual;
  assign LINK.hsync = q.hsync;
  assign LINK.vsync = q.vsync;
  assign LINK.bus_width_select = q.ctrl[CTRL_WIDE];
  assign LINK.dual_edge_select = q.ctrl[CTRL_DUAL];
  assign LINK.host_select_reset = q.ctrl[CTRL_HOST];
  assign LINK.skew_strap_enable = q.sken;
  assign LINK.general_inputs = q.gp_live;
  assign LINK.general_inputs_oe = q.gp_oe;

endmodule
`default_nettype wire

/* tb_pixel_input_port_capture.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_pixel_input_port_capture;
  import pic_pkg::*;
  typedef struct packed {logic act; logic hs; logic vs; logic [PIX_W-1:0] px;} pic_word_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] av_a = '0;
  logic av_r = 1'b0;
  logic av_w = 1'b0;
  logic [31:0] av_d = '0;
  logic [31:0] av_rd;
  logic av_wait;
  logic [PIX_W-1:0] px;
  logic valid, act, hs, vs, wide, dual, mact, mrst;
  logic [STRAP_W-1:0] strap;
  logic [GP_W-1:0] gp, skew, alow;
  logic collect = 1'b0;
  pic_word_t q[$];
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] modes [4] = '{32'h0000_0021, 32'h0000_0007, 32'h0000_0025, 32'h0000_0003};

  pic_if link();
  pic_source u_pic_source (.LINK(link), .CLK_IN(clk), .RST_IN(rst), .AVS_ADDRESS_IN(av_a),
    .AVS_READ_IN(av_r), .AVS_WRITE_IN(av_w), .AVS_WRITEDATA_IN(av_d),
    .AVS_READDATA_OUT(av_rd), .AVS_WAITREQUEST_OUT(av_wait));
  pic_device u_pic_device (.LINK(link), .CLK_IN(clk), .RST_IN(rst), .PIXEL_OUT(px),
    .WORD_VALID_OUT(valid), .ACTIVE_OUT(act), .HSYNC_OUT(hs), .VSYNC_OUT(vs),
    .WIDE_MODE_OUT(wide), .DUAL_MODE_OUT(dual), .STRAP_OUT(strap), .GP_OUT(gp),
    .SKEW_OUT(skew), .ADDR_LOW_OUT(alow), .MGMT_ACTIVE_OUT(mact), .MGMT_RESET_OUT(mrst));
  pic_asserts u_pic_asserts (.CLK_IN(clk), .RST_IN(rst), .pixel_data(link.pixel_data),
    .pixel_clock_pos(link.pixel_clock_pos), .pixel_clock_neg(link.pixel_clock_neg),
    .active_video_qualifier(link.active_video_qualifier),
    .bus_width_select(link.bus_width_select), .dual_edge_select(link.dual_edge_select),
    .host_select_reset(link.host_select_reset), .skew_strap_enable(link.skew_strap_enable),
    .general_inputs(link.general_inputs), .general_inputs_oe(link.general_inputs_oe),
    .WORD_VALID_OUT(valid), .WIDE_MODE_OUT(wide), .MGMT_ACTIVE_OUT(mact),
    .MGMT_RESET_OUT(mrst));

  // ----------------------------------------
  // clock, timeout and word capture
  // ----------------------------------------
  initial
  begin
    forever #25 clk = ~clk;
  end
  // the whole run is about 3800 cycles; a hang ends here
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      print_verdict();
    end
    if (collect && valid === 1'b1)
      q.push_back({act, hs, vs, px});
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is seen low at a rising edge
  task automatic av(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk);
    av_a <= a;
    av_r <= ~wr;
    av_w <= wr;
    av_d <= wd;
    do
      @(posedge clk);
    while (av_wait !== 1'b0);
    rd = av_rd;
    av_r <= 1'b0;
    av_w <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] x;
    av(1'b1, a, d, x);
  endtask

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    logic [31:0] x;
    av(1'b0, a, 32'h0000_0000, x);
    chk(x, exp);
  endtask

  // judges only complete runs; partial runs at either end are skipped
  task automatic check_lines(input logic vexp);
    int i, s, lines;
    logic [PIX_W-1:0] nxt;
    logic seen;
    i = 0;
    lines = 0;
    nxt = '0;
    seen = 1'b0;
    while (i < q.size() && q[i].act === q[0].act)
      i++;
    while (i < q.size())
    begin
      s = i;
      while (i < q.size() && q[i].act === q[s].act)
        i++;
      if (i < q.size())
      begin
        lines++;
        chk(32'(i - s), 32'h0000_0004);
        for (int j = s; j < i; j++)
        begin
          chk(32'(q[j].vs), 32'(vexp));
          if (q[s].act === 1'b1)
          begin
            // the source counts on across lines, so follow the running value
            if (!seen)
              nxt = q[s].px;
            seen = 1'b1;
            chk(32'(q[j].px), 32'(nxt));
            nxt = nxt + 24'h00_0001;
          end
          else
            chk({7'h00, q[j].hs, q[j].px}, {7'h00, (j - s) < 2, 24'h00_0000});
        end
      end
    end
    chk(32'(lines > 2), 32'h0000_0001);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk(REG_CTRL, 32'h0000_0002);
    rchk(REG_LEN, 32'h0008_0010);
    rchk(5'h14, 32'h0000_0000);
    wr(REG_LEN, 32'h0004_0004);
    wr(REG_STRAP, 32'h0000_00A5);
    foreach (modes[m])
    begin
      wr(REG_CTRL, modes[m]);
      repeat (120) @(posedge clk);
      q.delete();
      collect = 1'b1;
      repeat (600) @(posedge clk);
      collect = 1'b0;
      check_lines(modes[m][CTRL_VSYNC]);
      chk(32'(wide), 32'(modes[m][CTRL_WIDE]));
      chk(32'(dual), 32'(modes[m][CTRL_DUAL]));
      if (modes[m][CTRL_WIDE] == 1'b0)
        chk(32'(strap), 32'h0000_00A5);
    end
    chk(32'(mrst), 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_0043);
    wr(REG_GP, 32'h0000_0005);
    repeat (200) @(posedge clk);
    chk(32'(gp), 32'h0000_0005);
    wr(REG_CTRL, 32'h0000_0003);
    repeat (200) @(posedge clk);
    chk(32'(gp), 32'h0000_0000);
    wr(REG_CTRL, 32'h0000_0053);
    wr(REG_GP, 32'h0000_0003);
    repeat (200) @(posedge clk);
    chk(32'(skew), 32'h0000_0003);
    wr(REG_CTRL, 32'h0000_005B);
    wr(REG_GP, 32'h0000_0006);
    repeat (200) @(posedge clk);
    chk(32'(alow), 32'h0000_0006);
    chk({mact, mrst}, 32'h0000_0002);
    // width pin changed while in host mode must not move the mode
    wr(REG_CTRL, 32'h0000_0059);
    rchk(REG_CTRL, 32'h0000_0059);
    repeat (50) @(posedge clk);
    chk(32'(wide), 32'h0000_0001);
    print_verdict();
  end
endmodule
`default_nettype wire
